// [bench/mfw_host_model.sv]
// host controller model: avalon master, clear pin and move requests
// assumes the supervisor samples every input on rising mclk_i
`timescale 1ns/1ps
module mfw_host_model import mfw_pkg::*; (
  input wire logic mclk_i,
  input wire logic avs_waitrequest_i,
  input wire logic [31:0] avs_readdata_i,
  input wire logic move_accept_i,
  input wire logic move_reject_i,
  output logic [4:0] avs_address_o,
  output logic avs_read_o,
  output logic avs_write_o,
  output logic [3:0] avs_byteenable_o,
  output logic [31:0] avs_writedata_o,
  output logic fault_clear_o,
  output mfw_move_type move_o
);
  initial begin
    avs_address_o = '0;
    avs_read_o = 1'b0;
    avs_write_o = 1'b0;
    avs_byteenable_o = 4'hF;
    avs_writedata_o = '0;
    fault_clear_o = 1'b0;
    move_o = '0;
  end

  // ****************************************
  // requests, each entered just after a rising edge
  // ****************************************
  task automatic bus(input logic wr, input logic [4:0] a,
      input logic [31:0] wd, output logic [31:0] rd);
    avs_address_o <= a;
    avs_writedata_o <= wd;
    avs_write_o <= wr;
    avs_read_o <= !wr;
    do @(posedge mclk_i); while (avs_waitrequest_i !== 1'b0);
    rd = avs_readdata_i;
    avs_write_o <= 1'b0;
    avs_read_o <= 1'b0;
    avs_address_o <= ~a;
    avs_writedata_o <= ~wd;
    @(posedge mclk_i);
  endtask : bus

  // only called once the cause is gone; level held past the sync
  task automatic clear_pin();
    fault_clear_o <= 1'b1;
    repeat (4) @(posedge mclk_i);
    fault_clear_o <= 1'b0;
    @(posedge mclk_i);
  endtask : clear_pin

  // res is {accept, reject} seen one cycle after the request
  task automatic move(input logic dir_plus, output logic [1:0] res);
    move_o <= '{req: 1'b1, dir_plus: dir_plus};
    @(posedge mclk_i);
    move_o <= '{req: 1'b0, dir_plus: !dir_plus};
    @(posedge mclk_i);
    res = {move_accept_i, move_reject_i};
  endtask : move
endmodule : mfw_host_model

// [bench/test_motor_fault_warning_manager.sv]
// self-checking bench of the fault and warning supervisor
// assumes mfw_top with a short watchdog and the host model beside it
`timescale 1ns/1ps
module test_motor_fault_warning_manager import mfw_pkg::*; ;
  localparam int WD = 50;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [4:0] avs_address_i;
  logic avs_read_i;
  logic avs_write_i;
  logic [3:0] avs_byteenable_i;
  logic [31:0] avs_writedata_i;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic fault_clear_in_i;
  logic hw_plus_limit_i = 1'b0;
  logic hw_minus_limit_i = 1'b0;
  logic abs_cable_ok_i = 1'b1;
  logic inc_cable_ok_i = 1'b1;
  logic [NWARN-1:0] warn_event_i = '0;
  logic [31:0] position_i = '0;
  logic motor_busy_i = 1'b0;
  logic cpu_heartbeat_i = 1'b0;
  mfw_move_type move_i;
  logic move_accept_o;
  logic move_reject_o;
  mfw_out_type drv_o;
  logic irq_o;
  logic hb_run = 1'b1;
  integer seed = 32'haab97a53;
  int mismatches = 0;
  int tests_run = 0;
  logic [31:0] rd;
  logic [31:0] lim;
  logic [1:0] res;
  logic busy;
  logic [4:0] ra [5] = '{OFS_CTRL, OFS_LIM_PLUS, OFS_LIM_MINUS,
    OFS_IRQ_MASK, 5'h1C};
  logic [31:0] rv [5] = '{32'h2, 32'h7FFFFFFF, 32'h80000000, 32'h0, 32'h0};

  mfw_top #(.WDOG_LIMIT(WD)) mfw_top_i (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .fault_clear_in_i(fault_clear_in_i), .hw_plus_limit_i(hw_plus_limit_i),
    .hw_minus_limit_i(hw_minus_limit_i), .abs_cable_ok_i(abs_cable_ok_i),
    .inc_cable_ok_i(inc_cable_ok_i), .warn_event_i(warn_event_i),
    .position_i(position_i), .motor_busy_i(motor_busy_i),
    .cpu_heartbeat_i(cpu_heartbeat_i), .move_i(move_i),
    .move_accept_o(move_accept_o), .move_reject_o(move_reject_o),
    .drv_o(drv_o), .irq_o(irq_o));

  mfw_host_model mfw_host_model_i (.mclk_i(mclk_i),
    .avs_waitrequest_i(avs_waitrequest_o), .avs_readdata_i(avs_readdata_o),
    .move_accept_i(move_accept_o), .move_reject_i(move_reject_o),
    .avs_address_o(avs_address_i), .avs_read_o(avs_read_i),
    .avs_write_o(avs_write_i), .avs_byteenable_o(avs_byteenable_i),
    .avs_writedata_o(avs_writedata_i), .fault_clear_o(fault_clear_in_i),
    .move_o(move_i));

  initial begin
    forever #2.5 mclk_i = ~mclk_i;
  end

  always @(posedge mclk_i) begin
    if (hb_run) cpu_heartbeat_i <= ~cpu_heartbeat_i;
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic step(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : step

  task automatic check(input string what, input logic [31:0] e,
      input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask : check

  task automatic check_out(input string what, input mfw_out_type e);
    check(what, {8'h0, e}, {8'h0, drv_o});
  endtask : check_out

  task automatic do_reset();
    resetn_i <= 1'b0;
    step(6);
    resetn_i <= 1'b1;
    step(12);
  endtask : do_reset

  task automatic print_verdict();
    if (mismatches == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  // w < 0 is the quiet running state
  function automatic mfw_out_type exp_out(input int w, input logic bz);
    string s = "A3A5C0C5F1F5F8P5";
    exp_out = '0;
    exp_out.drive_ready_out = 1'b1;
    if (w >= 0) begin
      exp_out.warning_out = 1'b1;
      exp_out.led_orange = 1'b1;
      exp_out.seg_code = {s[2*w], s[2*w+1]};
      exp_out.servo_off = w inside {0, 2, 4, 7};
      exp_out.dyn_brake = exp_out.servo_off;
      exp_out.cycle_stop = w == 3 || (w inside {5, 6} && !bz);
    end
  endfunction : exp_out

  task automatic check_alarm(input string what, input logic [15:0] code);
    check(what, {12'h0, 4'h7, code}, {12'h0, drv_o.drive_ready_out,
      drv_o.servo_off, drv_o.dyn_brake, drv_o.led_orange, drv_o.seg_code});
  endtask : check_alarm

  task automatic check_limit(input logic plus, input logic [15:0] code);
    mfw_out_type e;
    e = exp_out(-1, 1'b0);
    e.plus_limit_out = plus;
    e.minus_limit_out = !plus;
    e.led_orange = 1'b1;
    e.seg_code = code;
    check_out("limit state", e);
    mfw_host_model_i.move(plus, res);
    check("move into limit", 32'h1, {30'h0, res});
    mfw_host_model_i.move(!plus, res);
    check("move out of limit", 32'h2, {30'h0, res});
  endtask : check_limit

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    do_reset();
    check_out("idle", exp_out(-1, 1'b0));
    mfw_host_model_i.bus(1'b1, 5'h1C, $random(seed), rd);
    for (int k = 0; k < 5; k++) begin
      mfw_host_model_i.bus(1'b0, ra[k], 32'h0, rd);
      check("register reset value", rv[k], rd);
    end
    mfw_host_model_i.bus(1'b1, OFS_IRQ_MASK, 32'h1, rd);
    for (int i = 0; i < NWARN; i++) begin
      busy = i == 5;
      motor_busy_i <= busy;
      warn_event_i <= 8'h01 << i;
      step(1);
      warn_event_i <= '0;
      step(4);
      check_out("warning set", exp_out(i, busy));
      if (busy) begin
        motor_busy_i <= 1'b0;
        step(3);
        check_out("stop after op", exp_out(i, 1'b0));
      end
      if (i == 0) begin
        check("irq raised", 32'h1, {31'h0, irq_o});
        mfw_host_model_i.bus(1'b0, OFS_IRQ_STAT, 32'h0, rd);
        check("irq status", 32'h1, rd);
        step(2);
        check("irq read clear", 32'h0, {31'h0, irq_o});
      end
      if ($random(seed) & 1) mfw_host_model_i.clear_pin();
      else mfw_host_model_i.bus(1'b1, OFS_CTRL, 32'h3, rd);
      step(3);
      check_out("warning cleared", exp_out(-1, 1'b0));
    end
    mfw_host_model_i.bus(1'b1, OFS_IRQ_MASK, 32'h0, rd);
    for (int d = 0; d < 2; d++) begin
      hw_plus_limit_i <= d[0];
      hw_minus_limit_i <= !d[0];
      step(6);
      check_limit(d[0], CODE_F3);
      hw_plus_limit_i <= 1'b0;
      hw_minus_limit_i <= 1'b0;
      step(6);
      check_out("hw limit left", exp_out(-1, 1'b0));
    end
    mfw_host_model_i.bus(1'b1, OFS_CTRL, 32'h0, rd);
    step(2);
    check("positive polarity", 32'hB00000, {8'h0, drv_o});
    mfw_host_model_i.bus(1'b1, OFS_CTRL, 32'h6, rd);
    for (int d = 0; d < 2; d++) begin
      lim = ($random(seed) & 32'h00FFFFFF) | 32'h100;
      if (!d[0]) lim = -lim;
      mfw_host_model_i.bus(1'b1, d[0] ? OFS_LIM_PLUS : OFS_LIM_MINUS, lim, rd);
      position_i <= lim;
      step(4);
      check_limit(d[0], CODE_F2);
      position_i <= d[0] ? lim - 32'h1 : lim + 32'h1;
      step(4);
      check_out("soft limit left", exp_out(-1, 1'b0));
    end
    position_i <= '0;
    inc_cable_ok_i <= 1'b0;
    step(6);
    check_alarm("inc cable alarm", CODE_A0);
    mfw_host_model_i.move(1'b1, res);
    check("move in alarm", 32'h1, {30'h0, res});
    inc_cable_ok_i <= 1'b1;
    do_reset();
    hb_run <= 1'b0;
    step(WD + 10);
    check_alarm("cpu alarm", CODE_C3);
    hb_run <= 1'b1;
    abs_cable_ok_i <= 1'b0;
    do_reset();
    check_alarm("abs cable at start", CODE_A0);
    abs_cable_ok_i <= 1'b1;
    do_reset();
    abs_cable_ok_i <= 1'b0;
    step(6);
    check_out("abs cable in run", exp_out(-1, 1'b0));
    print_verdict();
  end

  initial begin
    step(5000);
    mismatches++;
    print_verdict();
  end
endmodule : test_motor_fault_warning_manager

// [rtl/mfw_pkg.sv]
// package of the fault and warning supervisor: register map, codes, types
// assumes a 200 MHz system clock and 32-bit avalon-mm register access
package mfw_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLK_MHZ = 200;
  localparam int WDOG_TIME_US = 100;
  localparam int WDOG_CYCLES = WDOG_TIME_US * CLK_MHZ;
  localparam int SETTLE_CYCLES = 4;

  // ****************************************
  // register map, byte addresses
  // ****************************************
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_STATUS = 5'h04;
  localparam logic [4:0] OFS_CODE = 5'h08;
  localparam logic [4:0] OFS_IRQ_STAT = 5'h0C;
  localparam logic [4:0] OFS_IRQ_MASK = 5'h10;
  localparam logic [4:0] OFS_LIM_PLUS = 5'h14;
  localparam logic [4:0] OFS_LIM_MINUS = 5'h18;

  // ctrl fields and reset values
  localparam int CTRL_CLEAR_BIT = 0;
  localparam int CTRL_POLNEG_BIT = 1;
  localparam int CTRL_SOFTLIM_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h2;
  localparam logic [31:0] LIM_PLUS_RESET = 32'h7FFFFFFF;
  localparam logic [31:0] LIM_MINUS_RESET = 32'h80000000;
  localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

  // irq status fields
  localparam int IRQ_WARN_BIT = 0;
  localparam int IRQ_ALARM_BIT = 1;
  localparam int IRQ_LIM_IN_BIT = 2;
  localparam int IRQ_LIM_OUT_BIT = 3;

  // ****************************************
  // warning sources, one bit each
  // ****************************************
  localparam int NWARN = 8;
  localparam logic [NWARN-1:0] SERVO_OFF_MASK = 8'h95;
  localparam logic [NWARN-1:0] STOP_NOW_MASK = 8'h08;
  localparam logic [NWARN-1:0] STOP_LATER_MASK = 8'h60;

  // two ascii characters per display code
  localparam logic [15:0] CODE_NONE = 16'h0000;
  localparam logic [15:0] CODE_A0 = 16'h4130;
  localparam logic [15:0] CODE_C3 = 16'h4333;
  localparam logic [15:0] CODE_F2 = 16'h4632;
  localparam logic [15:0] CODE_F3 = 16'h4633;
  localparam logic [NWARN*16-1:0] WARN_CODES = {
    16'h5035, 16'h4638, 16'h4635, 16'h4631,
    16'h4335, 16'h4330, 16'h4135, 16'h4133};

  typedef enum {ST_SETTLE, ST_CHECK, ST_RUN} mfw_boot_type;

  // front panel and machine outputs
  typedef struct packed {
    logic warning_out;
    logic drive_ready_out;
    logic plus_limit_out;
    logic minus_limit_out;
    logic servo_off;
    logic dyn_brake;
    logic cycle_stop;
    logic led_orange;
    logic [15:0] seg_code;
  } mfw_out_type;

  // motion request from the motion planner
  typedef struct packed {
    logic req;
    logic dir_plus;
  } mfw_move_type;

endpackage : mfw_pkg

// [rtl/mfw_sync.sv]
// two flip-flop level synchroniser for pins entering the clock domain
// assumes inputs are quasi-static levels
`timescale 1ns/1ps
module mfw_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule : mfw_sync

// [rtl/mfw_top.sv]
// fault and warning supervisor of a servo motor driver
// assumes avalon-mm host, pins are asynchronous, planner on mclk_i
//
// What this block does
// - any warning drives the warning output active, closed for negative.
// - warnings that drop servo control also engage the dynamic brake.
// - clear input or clear command clears warnings; host clears after fix.
// - each warning code selects servo-off, no change or cycle stop.
// - program or tuning warning while moving stops after operation ends.
// - software and hardware over-travel report their own display codes.
// - reaching a limit activates that direction's over-travel output.
// - during over-travel only moves leaving the limit are accepted.
// - over-travel clears by itself once the motor leaves the area.
// - leaving counts by positioning, jogging or manual servo-off motion.
// - a stalled controlling processor raises the processor alarm.
// - absolute sensor cable is checked only at power-up.
// - incremental sensor cable is watched continuously.
// - any alarm drops drive ready, forces servo-off and dynamic brake.
// - any abnormality lights the orange led and shows its code.
//
// Local design decisions: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
module mfw_top import mfw_pkg::*; #(
  parameter int WDOG_LIMIT = WDOG_CYCLES
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic fault_clear_in_i,
  input wire logic hw_plus_limit_i,
  input wire logic hw_minus_limit_i,
  input wire logic abs_cable_ok_i,
  input wire logic inc_cable_ok_i,
  input wire logic [NWARN-1:0] warn_event_i,
  input wire logic [31:0] position_i,
  input wire logic motor_busy_i,
  input wire logic cpu_heartbeat_i,
  input wire mfw_move_type move_i,
  output logic move_accept_o,
  output logic move_reject_o,
  output mfw_out_type drv_o,
  output logic irq_o
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] be_merge(input logic [31:0] old,
      input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction : be_merge

  // contact level: 1 means closed
  function automatic logic contact(input logic act, input logic neg);
    return neg ? act : ~act;
  endfunction : contact

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [4:0] pins_s;

  mfw_sync #(.WIDTH(5)) u_sync (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .async_i({fault_clear_in_i, hw_plus_limit_i, hw_minus_limit_i,
              abs_cable_ok_i, inc_cable_ok_i}),
    .sync_o(pins_s)
  );

  logic clr_pin, hw_plus, hw_minus, abs_ok, inc_ok;
  assign {clr_pin, hw_plus, hw_minus, abs_ok, inc_ok} = pins_s;

  // ****************************************
  // state
  // ****************************************
  logic wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic [2:0] ctrl_q, ctrl_d;
  logic clr_cmd_q, clr_cmd_d;
  logic [31:0] lim_p_q, lim_p_d, lim_m_q, lim_m_d;
  logic [3:0] ist_q, ist_d, imask_q, imask_d;
  logic [NWARN-1:0] pend_q, pend_d;
  logic [15:0] wcode_q, wcode_d, acode_q, acode_d;
  logic alarm_q, alarm_d;
  logic [23:0] wdog_q, wdog_d;
  logic hb_q, hb_d;
  mfw_boot_type boot_q, boot_d;
  logic [2:0] settle_q, settle_d;
  logic plus_q, plus_d, minus_q, minus_d;
  logic acc_q, acc_d, rej_q, rej_d;
  mfw_out_type out_q, out_d;
  logic irq_q, irq_d;

  logic acc_rd, acc_wr, clear_now;
  logic soft_plus, soft_minus, plus_act, minus_act;
  logic lim_in, lim_out, alarm_set, warn_set;
  logic [15:0] wnew_code;

  assign acc_rd = avs_read_i && !wait_q;
  assign acc_wr = avs_write_i && !wait_q;
  assign clear_now = clr_pin || clr_cmd_q;

  // ****************************************
  // register bus slave
  // ****************************************
  always_comb begin
    wait_d = 1'b1;
    rdata_d = rdata_q;
    ctrl_d = ctrl_q;
    clr_cmd_d = 1'b0;
    lim_p_d = lim_p_q;
    lim_m_d = lim_m_q;
    imask_d = imask_q;
    if ((avs_read_i || avs_write_i) && wait_q) begin
      wait_d = 1'b0;
    end
    if (avs_read_i && wait_q) begin
      if (avs_address_i == OFS_CTRL) begin
        rdata_d = {29'h0, ctrl_q};
      end else if (avs_address_i == OFS_STATUS) begin
        rdata_d = {23'h0, boot_q == ST_RUN, out_q[23:16]};
      end else if (avs_address_i == OFS_CODE) begin
        rdata_d = {16'h0, out_q.seg_code};
      end else if (avs_address_i == OFS_IRQ_STAT) begin
        rdata_d = {28'h0, ist_q};
      end else if (avs_address_i == OFS_IRQ_MASK) begin
        rdata_d = {28'h0, imask_q};
      end else if (avs_address_i == OFS_LIM_PLUS) begin
        rdata_d = lim_p_q;
      end else if (avs_address_i == OFS_LIM_MINUS) begin
        rdata_d = lim_m_q;
      end else begin
        rdata_d = 32'h0;
      end
    end
    if (acc_wr) begin
      if (avs_address_i == OFS_CTRL) begin
        if (avs_byteenable_i[0]) begin
          ctrl_d = {avs_writedata_i[2:1], 1'b0};
          clr_cmd_d = avs_writedata_i[CTRL_CLEAR_BIT];
        end
      end else if (avs_address_i == OFS_IRQ_MASK) begin
        if (avs_byteenable_i[0]) begin
          imask_d = avs_writedata_i[3:0];
        end
      end else if (avs_address_i == OFS_LIM_PLUS) begin
        lim_p_d = be_merge(lim_p_q, avs_writedata_i, avs_byteenable_i);
      end else if (avs_address_i == OFS_LIM_MINUS) begin
        lim_m_d = be_merge(lim_m_q, avs_writedata_i, avs_byteenable_i);
      end
    end
  end

  // ****************************************
  // limits, motion gate, warnings, alarms
  // ****************************************
  assign soft_plus = ctrl_q[CTRL_SOFTLIM_BIT] &&
                     ($signed(position_i) >= $signed(lim_p_q));
  assign soft_minus = ctrl_q[CTRL_SOFTLIM_BIT] &&
                      ($signed(position_i) <= $signed(lim_m_q));
  assign plus_act = soft_plus || hw_plus;
  assign minus_act = soft_minus || hw_minus;
  assign lim_in = (plus_act && !plus_q) || (minus_act && !minus_q);
  assign lim_out = (!plus_act && plus_q) || (!minus_act && minus_q);
  assign warn_set = |(warn_event_i & ~pend_q);

  always_comb begin
    wnew_code = CODE_NONE;
    for (int i = NWARN - 1; i >= 0; i--) begin
      if (warn_event_i[i]) begin
        wnew_code = WARN_CODES[i*16 +: 16];
      end
    end
  end

  always_comb begin
    boot_d = boot_q;
    settle_d = settle_q;
    alarm_set = 1'b0;
    acode_d = acode_q;
    hb_d = cpu_heartbeat_i;
    wdog_d = (cpu_heartbeat_i != hb_q) ? 24'h0 : wdog_q + 24'h1;
    case (boot_q)
      ST_SETTLE: begin
        settle_d = settle_q + 3'h1;
        if (settle_q == 3'(SETTLE_CYCLES - 1)) begin
          boot_d = ST_CHECK;
        end
      end
      ST_CHECK: begin
        boot_d = ST_RUN;
        if (!abs_ok) begin
          alarm_set = 1'b1;
          acode_d = CODE_A0;
        end
      end
      default: begin
        if (!inc_ok) begin
          alarm_set = 1'b1;
          acode_d = CODE_A0;
        end
      end
    endcase
    if (wdog_q >= 24'(WDOG_LIMIT)) begin
      wdog_d = wdog_q;
      alarm_set = 1'b1;
      acode_d = CODE_C3;
    end
    if (alarm_q) begin
      acode_d = acode_q;
    end
    alarm_d = alarm_q || alarm_set;
    // set wins over clear, latched until cleared
    pend_d = (pend_q & ~{NWARN{clear_now}}) | warn_event_i;
    wcode_d = wcode_q;
    if (clear_now) begin
      wcode_d = CODE_NONE;
    end
    if (|warn_event_i && (wcode_q == CODE_NONE || clear_now)) begin
      wcode_d = wnew_code;
    end
    plus_d = plus_act;
    minus_d = minus_act;
    // only moves leaving the limit area pass
    acc_d = move_i.req && !alarm_q &&
            !(plus_q && move_i.dir_plus) &&
            !(minus_q && !move_i.dir_plus);
    rej_d = move_i.req && !acc_d;
  end

  // ****************************************
  // outputs and interrupt
  // ****************************************
  always_comb begin
    logic srv, any;
    srv = alarm_q || |(pend_q & SERVO_OFF_MASK);
    any = alarm_q || |pend_q || plus_q || minus_q;
    out_d.warning_out = contact(|pend_q, ctrl_q[CTRL_POLNEG_BIT]);
    out_d.drive_ready_out = contact(!alarm_q && boot_q == ST_RUN,
                                    ctrl_q[CTRL_POLNEG_BIT]);
    out_d.plus_limit_out = contact(plus_q, ctrl_q[CTRL_POLNEG_BIT]);
    out_d.minus_limit_out = contact(minus_q, ctrl_q[CTRL_POLNEG_BIT]);
    out_d.servo_off = srv;
    out_d.dyn_brake = srv;
    out_d.cycle_stop = |(pend_q & STOP_NOW_MASK) ||
        (|(pend_q & STOP_LATER_MASK) && !motor_busy_i);
    out_d.led_orange = any;
    if (alarm_q) begin
      out_d.seg_code = acode_q;
    end else if (plus_q || minus_q) begin
      out_d.seg_code = (hw_plus || hw_minus) ? CODE_F3 : CODE_F2;
    end else begin
      out_d.seg_code = wcode_q;
    end
    ist_d = ist_q;
    if (acc_rd && avs_address_i == OFS_IRQ_STAT) begin
      ist_d = ist_q & ~rdata_q[3:0];
    end
    ist_d[IRQ_WARN_BIT] = ist_d[IRQ_WARN_BIT] | warn_set;
    ist_d[IRQ_ALARM_BIT] = ist_d[IRQ_ALARM_BIT] | (alarm_set && !alarm_q);
    ist_d[IRQ_LIM_IN_BIT] = ist_d[IRQ_LIM_IN_BIT] | lim_in;
    ist_d[IRQ_LIM_OUT_BIT] = ist_d[IRQ_LIM_OUT_BIT] | lim_out;
    irq_d = |(ist_d & imask_q);
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0;
      ctrl_q <= CTRL_RESET;
      clr_cmd_q <= 1'b0;
      lim_p_q <= LIM_PLUS_RESET;
      lim_m_q <= LIM_MINUS_RESET;
      ist_q <= 4'h0;
      imask_q <= IRQ_MASK_RESET;
      pend_q <= '0;
      wcode_q <= CODE_NONE;
      acode_q <= CODE_NONE;
      alarm_q <= 1'b0;
      wdog_q <= 24'h0;
      hb_q <= 1'b0;
      boot_q <= ST_SETTLE;
      settle_q <= 3'h0;
      plus_q <= 1'b0;
      minus_q <= 1'b0;
      acc_q <= 1'b0;
      rej_q <= 1'b0;
      out_q <= '{led_orange: 1'b1, default: '0};
      irq_q <= 1'b0;
    end else begin
      wait_q <= wait_d;
      rdata_q <= rdata_d;
      ctrl_q <= ctrl_d;
      clr_cmd_q <= clr_cmd_d;
      lim_p_q <= lim_p_d;
      lim_m_q <= lim_m_d;
      ist_q <= ist_d;
      imask_q <= imask_d;
      pend_q <= pend_d;
      wcode_q <= wcode_d;
      acode_q <= acode_d;
      alarm_q <= alarm_d;
      wdog_q <= wdog_d;
      hb_q <= hb_d;
      boot_q <= boot_d;
      settle_q <= settle_d;
      plus_q <= plus_d;
      minus_q <= minus_d;
      acc_q <= acc_d;
      rej_q <= rej_d;
      out_q <= out_d;
      irq_q <= irq_d;
    end
  end

  assign avs_waitrequest_o = wait_q;
  assign avs_readdata_o = rdata_q;
  assign move_accept_o = acc_q;
  assign move_reject_o = rej_q;
  assign drv_o = out_q;
  assign irq_o = irq_q;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_warn_in;
    |warn_event_i && !clear_now;
  endsequence
  sequence s_alarm_up;
    !alarm_q ##1 alarm_q;
  endsequence

  a_warn_output: assert property (s_warn_in |-> ##2 (drv_o.warning_out
      == ctrl_q[CTRL_POLNEG_BIT] || $past(clear_now)))
    else $error("warning output not active after warning");
  a_brake_servo: assert property (alarm_q || |(pend_q & SERVO_OFF_MASK)
      |=> drv_o.dyn_brake) else $error("dynamic brake not engaged");
  a_clear_pend: assert property (clear_now && !(|warn_event_i) |=>
      pend_q == '0) else $error("warning not cleared");
  a_servo_type: assert property (|(pend_q & SERVO_OFF_MASK) |=>
      out_q.servo_off) else $error("servo not dropped");
  a_late_stop: assert property (|(pend_q & STOP_LATER_MASK) &&
      motor_busy_i && !(|(pend_q & STOP_NOW_MASK)) |=> !out_q.cycle_stop)
    else $error("cycle stop before operation finished");
  a_limit_gate: assert property (move_i.req && move_i.dir_plus && plus_q
      |=> move_reject_o && !move_accept_o)
    else $error("move into limit accepted");
  a_limit_auto: assert property (plus_q && !plus_act && !clear_now
      |=> !plus_q) else $error("over-travel did not clear");
  a_warn_latch: assert property (|pend_q && !clear_now |=> |pend_q
      && wcode_q == $past(wcode_q))
    else $error("warning dropped without clear");
  a_alarm_stop: assert property (s_alarm_up |=> drv_o.servo_off &&
      drv_o.dyn_brake && drv_o.led_orange)
    else $error("alarm did not stop motor");
  a_abs_once: assert property (boot_q == ST_RUN && inc_ok &&
      wdog_q < 24'(WDOG_LIMIT) && !alarm_q |=> !alarm_q)
    else $error("alarm raised without cause");

endmodule : mfw_top
